// >>> dv/tb.sv
// self-checking bench for the serial control block
`timescale 1ns/1ps
module tb;
  logic sys_clk, rstn, cpuWr, cpuRd, timerOutIn, loopSel, waitSeen;
  logic cpuAck, cpuWait, rxIrq, txFifoReady, rxLine;
  logic [15:0] cpuAddr;
  logic [7:0] cpuWdata, cpuRdata, portIn, portOut, portOe, rdv;
  int errCount, testsRun, irqCount, tCnt;
  logic [7:0] txq[$];

  assign portIn = {6'h3F, loopSel ? portOut[0] : rxLine, 1'b1};

  ubs_serial_ctrl dut_u (.sys_clk(sys_clk), .rstn(rstn),
    .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd),
    .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .cpuAck(cpuAck),
    .cpuWait(cpuWait), .portIn(portIn), .portOut(portOut),
    .portOe(portOe), .timerOutIn(timerOutIn), .rxIrq(rxIrq),
    .txFifoReady(txFifoReady));
  ubs_remote_uart remote_u (.sys_clk(sys_clk), .rxLine(rxLine));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // timer output with a period of six clocks
  always @(posedge sys_clk) begin
    tCnt <= (tCnt == 2) ? 0 : tCnt + 1;
    if (tCnt == 2) timerOutIn <= ~timerOutIn;
    if (rxIrq === 1'b1) irqCount <= irqCount + 1;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tmo();
    errCount++;
    $display("mismatch at %0t: seen %h expected %h", $time, 0, 1);
    conclude();
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [15:0] a,
      input logic [7:0] d);
    int n;
    waitSeen = 1'b0;
    @(posedge sys_clk);
    cpuAddr <= a;
    cpuWdata <= d;
    cpuWr <= wr;
    cpuRd <= ~wr;
    @(posedge sys_clk);
    cpuWr <= 1'b0;
    cpuRd <= 1'b0;
    for (n = 0; n < 8; n++) begin
      @(negedge sys_clk);
      if (cpuWait === 1'b1) waitSeen = 1'b1;
      if (cpuAck === 1'b1) break;
    end
    if (n == 8) tmo();
    rdv = cpuRdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    chk(rdv, exp);
  endtask

  task automatic errRd(input logic [7:0] exp);
    rd(ubs_pkg::ERR_ADDR, exp);
    chk({7'h00, waitSeen}, 8'h01);
  endtask

  task automatic waitIrq(input int target, input int lim);
    int n;
    for (n = 0; n < lim && irqCount < target; n++) @(negedge sys_clk);
    if (irqCount < target) tmo();
  endtask

  function automatic logic [7:0] md(input logic [2:0] ctl,
      input logic [1:0] ps, input logic cl);
    return {ctl, ps, cl, 2'b01};
  endfunction

  function automatic int basePer(input int sel);
    case (sel)
      0: return 6;
      1: return 2;
      2: return 8;
      default: return 32;
    endcase
  endfunction

  // stop, set divider, power on, then enable reception
  task automatic cfg(input logic [7:0] baud, input logic [1:0] ps,
      input logic cl);
    wr(ubs_pkg::MODE_ADDR, 8'h81);
    wr(ubs_pkg::MODE_ADDR, 8'h01);
    wr(ubs_pkg::BAUD_ADDR, baud);
    wr(ubs_pkg::MODE_ADDR, md(3'b100, ps, cl));
    wr(ubs_pkg::MODE_ADDR, md(3'b101, ps, cl));
  endtask

  task automatic frame(input logic [7:0] d, input int cyc, input logic cl,
      input logic [1:0] ps, input logic flip, input logic bad);
    int base;
    base = irqCount;
    remote_u.send(d, cyc, cl, ps, flip, bad);
    waitIrq(base + 1, 4 * cyc);
    chk(8'(irqCount - base), 8'h01);
    errRd({5'h00, flip & ps[1], bad, 1'b0});
    rd(ubs_pkg::DATA_ADDR, cl ? d : {1'b0, d[6:0]});
  endtask

  initial begin
    int k, sel, n, base;
    logic [7:0] d, v;
    logic [1:0] ps;
    logic c;
    rstn = 1'b0;
    cpuWr = 1'b0;
    cpuRd = 1'b0;
    cpuAddr = 16'h0000;
    cpuWdata = 8'h00;
    timerOutIn = 1'b0;
    loopSel = 1'b0;
    void'($urandom(32'hFF63));
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    // ==========================================================
    // reset values and access kinds
    rd(ubs_pkg::DIR_ADDR, 8'hFF);
    rd(ubs_pkg::MODE_ADDR, 8'h01);
    rd(ubs_pkg::BAUD_ADDR, 8'h1F);
    errRd(8'h00);
    chk(portOe, 8'h00);
    rd(16'hFF00, 8'h00);
    wr(ubs_pkg::BAUD_ADDR, 8'hFF);
    rd(ubs_pkg::BAUD_ADDR, 8'hDF);
    v = $urandom;
    wr(ubs_pkg::DIR_ADDR, v);
    rd(ubs_pkg::DIR_ADDR, v);
    chk(portOe, ~v);
    wr(ubs_pkg::DIR_ADDR, 8'hFE);
    wr(ubs_pkg::LATCH_ADDR, 8'h01);
    // ==========================================================
    // random frames over clock sources, dividers and parity modes
    for (int i = 0; i < 12; i++) begin
      sel = i % 4;
      k = (sel == 3) ? 8 : 8 + $urandom % 24;
      ps = 2'((i + i / 4) % 4);
      d = $urandom;
      c = 1'($urandom);
      cfg({2'(sel), 1'b0, 5'(k)}, ps, c);
      frame(d, 2 * k * basePer(sel), c, ps,
        1'($urandom), i % 3 == 2);
    end
    // ==========================================================
    // overrun keeps the first byte, read clears the flags
    cfg(8'h48, ubs_pkg::PAR_NONE, 1'b1);
    base = irqCount;
    d = $urandom;
    remote_u.send(d, 32, 1'b1, ubs_pkg::PAR_NONE, 1'b0, 1'b0);
    remote_u.send(~d, 32, 1'b1, ubs_pkg::PAR_NONE, 1'b0, 1'b0);
    waitIrq(base + 2, 64);
    errRd(8'h01);
    rd(ubs_pkg::DATA_ADDR, d);
    errRd(8'h00);
    // ==========================================================
    // clearing receive enable wipes a pending parity error
    cfg(8'h48, ubs_pkg::PAR_EVEN, 1'b1);
    base = irqCount;
    remote_u.send(d, 32, 1'b1, ubs_pkg::PAR_EVEN, 1'b1, 1'b0);
    waitIrq(base + 1, 64);
    wr(ubs_pkg::MODE_ADDR, md(3'b100, ubs_pkg::PAR_EVEN, 1'b1));
    errRd(8'h00);
    // ==========================================================
    // prohibited divider freezes reception
    cfg(8'h47, ubs_pkg::PAR_NONE, 1'b1);
    base = irqCount;
    remote_u.send(d, 28, 1'b1, ubs_pkg::PAR_NONE, 1'b0, 1'b0);
    repeat (200) @(posedge sys_clk);
    chk(8'(irqCount - base), 8'h00);
    errRd(8'h00);
    // ==========================================================
    // fill the transmit fifo behind a running transmitter, loop it back
    cfg(8'h48, ubs_pkg::PAR_EVEN, 1'b1);
    @(posedge sys_clk);
    loopSel <= 1'b1;
    base = irqCount;
    wr(ubs_pkg::MODE_ADDR, md(3'b111, ubs_pkg::PAR_EVEN, 1'b1));
    for (n = 0; n < 20 && txFifoReady === 1'b1; n++) begin
      d = $urandom;
      txq.push_back(d);
      wr(ubs_pkg::DATA_ADDR, d);
      repeat (2) @(negedge sys_clk);
    end
    // fifo words, its output register and the byte in the shifter
    chk(8'(n), 8'(ubs_pkg::FIFO_DEPTH + 2));
    foreach (txq[j]) begin
      waitIrq(base + j + 1, 800);
      rd(ubs_pkg::DATA_ADDR, txq[j]);
    end
    errRd(8'h00);
    // ==========================================================
    // stop mode hands the pins back to the port latch
    wr(ubs_pkg::MODE_ADDR, 8'h81);
    wr(ubs_pkg::MODE_ADDR, 8'h01);
    v = $urandom;
    wr(ubs_pkg::LATCH_ADDR, v);
    repeat (2) @(negedge sys_clk);
    chk(portOut, v);
    chk(portOe, 8'h01);
    errRd(8'h00);
    conclude();
  end
endmodule

// >>> dv/ubs_remote_uart.sv
// remote serial transceiver that drives the receive line
`timescale 1ns/1ps
module ubs_remote_uart (
  input wire logic sys_clk,
  output logic rxLine
);
  // line idles high, as with a pull-up
  initial rxLine = 1'b1;

  task automatic putBit(input logic b, input int cyc);
    rxLine <= b;
    repeat (cyc) @(posedge sys_clk);
  endtask

  // start, data lsb first, optional parity, one stop, one idle bit
  task automatic send(input logic [7:0] d, input int cyc, input logic cl,
      input logic [1:0] ps, input logic flip, input logic badStop);
    logic p;
    p = cl ? ^d : ^d[6:0];
    @(posedge sys_clk);
    putBit(1'b0, cyc);
    for (int i = 0; i < (cl ? 8 : 7); i++) begin
      putBit(d[i], cyc);
    end
    if (ps == ubs_pkg::PAR_EVEN) putBit(p ^ flip, cyc);
    if (ps == ubs_pkg::PAR_ODD) putBit(~p ^ flip, cyc);
    if (ps == ubs_pkg::PAR_ZERO) putBit(flip, cyc);
    if (badStop) begin
      // low past the sample point, high again before a start would confirm
      putBit(1'b0, cyc * 3 / 4);
      putBit(1'b1, cyc / 4);
    end else begin
      putBit(1'b1, cyc);
    end
    putBit(1'b1, cyc);
  endtask
endmodule

// >>> logic/ubs_fifo.sv
// transmit fifo with registered read data
`timescale 1ns/1ps
module ubs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  ubs_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic notFull;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } ubs_fifo_state_type;
  ubs_fifo_state_type q, d;
  logic push;
  logic load;
  logic take;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    push = port.pushValid && q.notFull;
    take = q.outValid && port.popReady;
    load = (q.count != '0) && (!q.outValid || take);
    if (push) begin
      d.mem[q.wrPtr] = port.pushData;
      d.wrPtr = q.wrPtr + AW'(1);
    end
    if (load) begin
      d.outData = q.mem[q.rdPtr];
      d.outValid = 1'b1;
      d.rdPtr = q.rdPtr + AW'(1);
    end else if (take) begin
      d.outValid = 1'b0;
    end
    d.count = q.count + (AW+1)'(push) - (AW+1)'(load);
    if (port.clear) begin
      d.wrPtr = '0;
      d.rdPtr = '0;
      d.count = '0;
      d.outValid = 1'b0;
    end
    d.notFull = d.count != (AW+1)'(DEPTH);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.notFull <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign port.pushReady = q.notFull;
  assign port.popValid = q.outValid;
  assign port.popData = q.outData;
endmodule

// >>> logic/ubs_fifo_if.sv
// stream carrier between the block and its transmit fifo
`timescale 1ns/1ps
interface ubs_fifo_if #(parameter int WIDTH = 8);
  logic pushValid;
  logic pushReady;
  logic [WIDTH-1:0] pushData;
  logic popValid;
  logic popReady;
  logic [WIDTH-1:0] popData;
  logic clear;
  modport owner(output pushValid, pushData, popReady, clear,
    input pushReady, popValid, popData);
  modport fifo(input pushValid, pushData, popReady, clear,
    output pushReady, popValid, popData);
endinterface

// >>> logic/ubs_pkg.sv
// shared constants and types for the serial error, baud and stop block
package ubs_pkg;
  // ==========================================================
  // register addresses on the cpu memory bus
  localparam logic [15:0] LATCH_ADDR = 16'hFF01;
  localparam logic [15:0] DIR_ADDR = 16'hFF21;
  localparam logic [15:0] MODE_ADDR = 16'hFF70;
  localparam logic [15:0] BAUD_ADDR = 16'hFF71;
  localparam logic [15:0] DATA_ADDR = 16'hFF72;
  localparam logic [15:0] ERR_ADDR = 16'hFF73;
  // ==========================================================
  // reset values
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] BAUD_RST = 8'h1F;
  localparam logic [2:0] ERR_RST = 3'h0;
  localparam logic [7:0] RXBUF_RST = 8'hFF;
  // ==========================================================
  // field positions
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_CL = 2;
  localparam int MODE_SL = 1;
  localparam logic [7:0] MODE_FIXED1 = 8'h01;
  localparam logic [7:0] BAUD_MASK = 8'hDF;
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OVE = 0;
  localparam int TX_PIN = 0;
  localparam int RX_PIN = 1;
  // ==========================================================
  // parity modes, clock sources and counts
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam logic [1:0] SRC_TIMER = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV8 = 2'h2;
  localparam logic [5:0] PRE_DIV2 = 6'h02;
  localparam logic [5:0] PRE_DIV8 = 6'h08;
  localparam logic [5:0] PRE_DIV32 = 6'h20;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [2:0] LAST_BIT7 = 3'h6;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } ubs_rx_state_type;
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } ubs_tx_state_type;
endpackage

// >>> logic/ubs_serial_ctrl.sv
// serial error status, baud generator, stop mode and port routing
`timescale 1ns/1ps
// Summary of operation
// - error status three low flags, cleared off
// - reading error status clears its flags
// - parity mismatch at frame end sets flag
// - missing stop bit sets framing flag
// - only the first stop bit checked
// - frame done with unread buffer sets overrun
// - overrun discards new byte, buffer kept
// - parity flag follows parity select bits
// - zero parity never raises parity flag
// - reception interrupt on every finished frame
// - error status read inserts one wait
// - clock select picks timer or prescaled clock
// - divider k divides base; below 8 prohibited
// - bit rate is divider output halved
// - baud register resets 1FH, bit5 zero
// - power off resets circuit, stops clock
// - enable cleared resets its own circuit
// - power off forces receive input high
// - all three controls clear means stop mode
// - direction bit 0 output, 1 input
module ubs_serial_ctrl (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuWr,
  input wire logic cpuRd,
  input wire logic [7:0] cpuWdata,
  output logic [7:0] cpuRdata,
  output logic cpuAck,
  output logic cpuWait,
  input wire logic [7:0] portIn,
  output logic [7:0] portOut,
  output logic [7:0] portOe,
  input wire logic timerOutIn,
  output logic rxIrq,
  output logic txFifoReady
);
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] mode;
    logic [7:0] baud;
    logic [2:0] err;
    logic [7:0] rxBuf;
    logic rxFull;
    logic [7:0] rdData;
    logic ack;
    logic rdWait;
    logic irq;
    logic [5:0] pre;
    logic tmrS1;
    logic tmrS2;
    logic tmrS3;
    logic rxS1;
    logic rxS2;
    logic [4:0] rxDiv;
    logic [4:0] txDiv;
    ubs_pkg::ubs_rx_state_type rxSt;
    logic [7:0] rxShift;
    logic [2:0] rxCnt;
    logic rxPhase;
    logic rxPar;
    ubs_pkg::ubs_tx_state_type txSt;
    logic [7:0] txShift;
    logic [2:0] txCnt;
    logic txPhase;
    logic txPar;
    logic txLine;
    logic [7:0] pOut;
    logic [7:0] pOe;
  } ubs_ctrl_state_type;
  ubs_ctrl_state_type q, d;
  ubs_fifo_if #(.WIDTH(ubs_pkg::DATA_W)) fifoIf ();
  logic power, txe, rxe, cl, rxIn, baseTick, rxHalf, txHalf, rxDone;
  logic take, clearErr, pe, fe;
  logic [1:0] par;
  logic [4:0] k;
  logic [5:0] preLim;
  logic [7:0] rxData;
  logic [2:0] lastBit;

  ubs_fifo #(.WIDTH(ubs_pkg::DATA_W), .DEPTH(ubs_pkg::FIFO_DEPTH)) txFifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .port(fifoIf)
  );

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    power = q.mode[ubs_pkg::MODE_POWER];
    txe = q.mode[ubs_pkg::MODE_TXE];
    rxe = q.mode[ubs_pkg::MODE_RXE];
    cl = q.mode[ubs_pkg::MODE_CL];
    par = q.mode[4:3];
    lastBit = cl ? ubs_pkg::LAST_BIT8 : ubs_pkg::LAST_BIT7;
    k = q.baud[4:0];
    rxIn = power ? q.rxS2 : 1'b1;
    rxHalf = 1'b0;
    txHalf = 1'b0;
    rxDone = 1'b0;
    pe = 1'b0;
    fe = 1'b0;
    clearErr = 1'b0;
    rxData = cl ? q.rxShift : {1'b0, q.rxShift[7:1]};
    d.ack = 1'b0;
    d.irq = 1'b0;
    d.rdWait = 1'b0;
    d.tmrS1 = timerOutIn;
    d.tmrS2 = q.tmrS1;
    d.tmrS3 = q.tmrS2;
    d.rxS1 = portIn[ubs_pkg::RX_PIN];
    d.rxS2 = q.rxS1;
    fifoIf.pushValid = 1'b0;
    fifoIf.pushData = cpuWdata;
    fifoIf.popReady = 1'b0;
    fifoIf.clear = !power || !txe;
    // ----------------------------------------------------------
    // cpu bus
    take = !q.rdWait;
    if (q.rdWait) begin
      d.ack = 1'b1;
      d.rdData = {5'h00, q.err};
      clearErr = 1'b1;
    end else if (cpuRd) begin
      if (cpuAddr == ubs_pkg::ERR_ADDR) begin
        d.rdWait = 1'b1;
      end else begin
        d.ack = 1'b1;
        unique case (cpuAddr)
          ubs_pkg::DIR_ADDR: d.rdData = q.dir;
          ubs_pkg::LATCH_ADDR: d.rdData = q.latch;
          ubs_pkg::MODE_ADDR: d.rdData = q.mode;
          ubs_pkg::BAUD_ADDR: d.rdData = q.baud;
          ubs_pkg::DATA_ADDR: d.rdData = q.rxBuf;
          default: d.rdData = 8'h00;
        endcase
        if (cpuAddr == ubs_pkg::DATA_ADDR) begin
          d.rxFull = 1'b0;
        end
      end
    end else if (cpuWr) begin
      d.ack = 1'b1;
      unique case (cpuAddr)
        ubs_pkg::DIR_ADDR: d.dir = cpuWdata;
        ubs_pkg::LATCH_ADDR: d.latch = cpuWdata;
        ubs_pkg::MODE_ADDR: d.mode = cpuWdata | ubs_pkg::MODE_FIXED1;
        ubs_pkg::BAUD_ADDR: d.baud = cpuWdata & ubs_pkg::BAUD_MASK;
        ubs_pkg::DATA_ADDR: fifoIf.pushValid = take;
        default: d.ack = 1'b1;
      endcase
    end
    // ----------------------------------------------------------
    // base clock: timer edge or prescaled system clock
    unique case (q.baud[7:6])
      ubs_pkg::SRC_DIV2: preLim = ubs_pkg::PRE_DIV2;
      ubs_pkg::SRC_DIV8: preLim = ubs_pkg::PRE_DIV8;
      default: preLim = ubs_pkg::PRE_DIV32;
    endcase
    if (q.baud[7:6] == ubs_pkg::SRC_TIMER) begin
      baseTick = q.tmrS2 && !q.tmrS3;
      d.pre = 6'h00;
    end else begin
      baseTick = q.pre == preLim - 6'h01;
      d.pre = baseTick ? 6'h00 : q.pre + 6'h01;
    end
    // divider output is half a bit; prohibited k gives no clock
    if (baseTick && k[4:3] != 2'b00) begin
      rxHalf = q.rxDiv == k - 5'h01;
      txHalf = q.txDiv == k - 5'h01;
      d.rxDiv = rxHalf ? 5'h00 : q.rxDiv + 5'h01;
      d.txDiv = txHalf ? 5'h00 : q.txDiv + 5'h01;
    end
    // ----------------------------------------------------------
    // receiver; two half periods per bit
    if (rxHalf) begin
      d.rxPhase = !q.rxPhase;
    end
    unique case (q.rxSt)
      ubs_pkg::RX_IDLE: begin
        d.rxDiv = 5'h00;
        d.rxPhase = 1'b0;
        if (!rxIn) begin
          d.rxSt = ubs_pkg::RX_START;
        end
      end
      ubs_pkg::RX_START: begin
        if (rxHalf) begin
          d.rxSt = rxIn ? ubs_pkg::RX_IDLE : ubs_pkg::RX_DATA;
          d.rxPhase = 1'b0;
          d.rxCnt = 3'h0;
        end
      end
      ubs_pkg::RX_DATA: begin
        if (rxHalf && q.rxPhase) begin
          d.rxShift = {rxIn, q.rxShift[7:1]};
          d.rxCnt = q.rxCnt + 3'h1;
          if (q.rxCnt == lastBit) begin
            d.rxSt = (par == ubs_pkg::PAR_NONE) ? ubs_pkg::RX_STOP
              : ubs_pkg::RX_PARITY;
          end
        end
      end
      ubs_pkg::RX_PARITY: begin
        if (rxHalf && q.rxPhase) begin
          d.rxPar = rxIn;
          d.rxSt = ubs_pkg::RX_STOP;
        end
      end
      ubs_pkg::RX_STOP: begin
        if (rxHalf && q.rxPhase) begin
          rxDone = 1'b1;
          d.rxSt = ubs_pkg::RX_IDLE;
        end
      end
      default: d.rxSt = ubs_pkg::RX_IDLE;
    endcase
    if (rxDone) begin
      unique case (par)
        ubs_pkg::PAR_ODD: pe = !(^rxData ^ q.rxPar);
        ubs_pkg::PAR_EVEN: pe = ^rxData ^ q.rxPar;
        default: pe = 1'b0;
      endcase
      fe = !rxIn;
      d.irq = 1'b1;
      if (!q.rxFull) begin
        d.rxBuf = rxData;
        d.rxFull = 1'b1;
      end
    end
    d.err = clearErr ? ubs_pkg::ERR_RST : q.err;
    d.err = d.err | {pe, fe, rxDone && q.rxFull};
    // ----------------------------------------------------------
    // transmitter
    if (txHalf) begin
      d.txPhase = !q.txPhase;
    end
    unique case (q.txSt)
      ubs_pkg::TX_IDLE: begin
        d.txDiv = 5'h00;
        d.txPhase = 1'b0;
        d.txLine = 1'b1;
        fifoIf.popReady = power && txe;
        if (fifoIf.popValid && power && txe) begin
          d.txShift = cl ? fifoIf.popData : {1'b0, fifoIf.popData[6:0]};
          d.txPar = (par == ubs_pkg::PAR_EVEN) ? ^d.txShift
            : (par == ubs_pkg::PAR_ODD) ? !(^d.txShift) : 1'b0;
          d.txLine = 1'b0;
          d.txSt = ubs_pkg::TX_START;
        end
      end
      ubs_pkg::TX_START: begin
        if (txHalf && q.txPhase) begin
          d.txLine = q.txShift[0];
          d.txCnt = 3'h0;
          d.txSt = ubs_pkg::TX_DATA;
        end
      end
      ubs_pkg::TX_DATA: begin
        if (txHalf && q.txPhase) begin
          d.txShift = {1'b1, q.txShift[7:1]};
          d.txCnt = q.txCnt + 3'h1;
          d.txLine = q.txShift[1];
          if (q.txCnt == lastBit) begin
            d.txCnt = 3'h0;
            d.txLine = (par == ubs_pkg::PAR_NONE) ? 1'b1 : q.txPar;
            d.txSt = (par == ubs_pkg::PAR_NONE) ? ubs_pkg::TX_STOP
              : ubs_pkg::TX_PARITY;
          end
        end
      end
      ubs_pkg::TX_PARITY: begin
        if (txHalf && q.txPhase) begin
          d.txLine = 1'b1;
          d.txSt = ubs_pkg::TX_STOP;
        end
      end
      ubs_pkg::TX_STOP: begin
        if (txHalf && q.txPhase) begin
          d.txCnt = 3'h1;
          if (!q.mode[ubs_pkg::MODE_SL] || q.txCnt != 3'h0) begin
            d.txSt = ubs_pkg::TX_IDLE;
          end
        end
      end
      default: d.txSt = ubs_pkg::TX_IDLE;
    endcase
    // ----------------------------------------------------------
    // disables: power stops every clock, enables reset their side
    if (!power || !rxe) begin
      d.err = ubs_pkg::ERR_RST;
      d.rxSt = ubs_pkg::RX_IDLE;
      d.rxDiv = 5'h00;
      d.irq = 1'b0;
    end
    if (!power || !txe) begin
      d.txSt = ubs_pkg::TX_IDLE;
      d.txDiv = 5'h00;
      d.txLine = 1'b1;
    end
    if (!power) begin
      d.pre = 6'h00;
      d.rxBuf = ubs_pkg::RXBUF_RST;
      d.rxFull = 1'b0;
    end
    // ----------------------------------------------------------
    // pins: ordinary port when stopped, tx pin output is serial data anded with its latch bit when enabled
    d.pOe = ~d.dir;
    d.pOut = d.latch;
    if (power && txe) begin
      d.pOut[ubs_pkg::TX_PIN] = d.txLine & d.latch[ubs_pkg::TX_PIN];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.dir <= ubs_pkg::DIR_RST;
      q.latch <= ubs_pkg::LATCH_RST;
      q.mode <= ubs_pkg::MODE_RST;
      q.baud <= ubs_pkg::BAUD_RST;
      q.rxBuf <= ubs_pkg::RXBUF_RST;
      q.tmrS1 <= 1'b1;
      q.tmrS2 <= 1'b1;
      q.tmrS3 <= 1'b1;
      q.rxS1 <= 1'b1;
      q.rxS2 <= 1'b1;
      q.txLine <= 1'b1;
      q.pOe <= ~ubs_pkg::DIR_RST;
      q.pOut <= ubs_pkg::LATCH_RST;
    end else begin
      q <= d;
    end
  end

  assign cpuRdata = q.rdData;
  assign cpuAck = q.ack;
  assign cpuWait = q.rdWait;
  assign portOut = q.pOut;
  assign portOe = q.pOe;
  assign rxIrq = q.irq;
  assign txFifoReady = fifoIf.pushReady;

  // ==========================================================
  // checks
  property p_err_off;
    @(posedge sys_clk) disable iff (!rstn)
      (!power || !rxe) |=> (q.err == 3'h0);
  endproperty
  a_err_off: assert property (p_err_off) else $error("err not cleared");
  property p_err_read;
    @(posedge sys_clk) disable iff (!rstn)
      (q.rdWait && !rxDone) |=> (q.err == 3'h0) && cpuAck;
  endproperty
  a_err_read: assert property (p_err_read) else $error("read no clear");
  property p_err_wait;
    @(posedge sys_clk) disable iff (!rstn)
      (cpuRd && !cpuWait && cpuAddr == ubs_pkg::ERR_ADDR)
        |=> (cpuWait && !cpuAck) ##1 (cpuAck && !cpuWait);
  endproperty
  a_err_wait: assert property (p_err_wait) else $error("no wait cycle");
  property p_parity;
    @(posedge sys_clk) disable iff (!rstn)
      (rxDone && pe && power && rxe) |=> q.err[ubs_pkg::ERR_PE];
  endproperty
  a_parity: assert property (p_parity) else $error("parity lost");
  property p_zero_par;
    @(posedge sys_clk) disable iff (!rstn)
      (par[1] == 1'b0 && !q.err[ubs_pkg::ERR_PE])
        |=> !q.err[ubs_pkg::ERR_PE];
  endproperty
  a_zero_par: assert property (p_zero_par) else $error("parity set");
  property p_frame;
    @(posedge sys_clk) disable iff (!rstn)
      (rxDone && !rxIn && power && rxe) |=> q.err[ubs_pkg::ERR_FE];
  endproperty
  a_frame: assert property (p_frame) else $error("framing lost");
  property p_overrun;
    @(posedge sys_clk) disable iff (!rstn)
      (rxDone && q.rxFull && power && rxe)
        |=> q.err[ubs_pkg::ERR_OVE] && $stable(q.rxBuf);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun wrong");
  property p_irq;
    @(posedge sys_clk) disable iff (!rstn)
      (rxDone && power && rxe) |=> rxIrq ##1 !rxIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_prohib;
    @(posedge sys_clk) disable iff (!rstn)
      (k[4:3] == 2'b00) |-> !rxHalf && !txHalf;
  endproperty
  a_prohib: assert property (p_prohib) else $error("divider ran");
  property p_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (!rxDone && !q.rdWait && power && rxe) |=> $stable(q.err);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved");
endmodule
